// >>> design/fpm_ctrl.sv
/*
 Host-side controller for a fast-page-mode parity memory module.
 Assumes synchronous pins, one module position, external pull-ups on presence bits.
*/
`timescale 1ns/1ps
// Summary of operation
// - Write enable falls only in the early-write window, never between windows.
// - Write data held stable past the column strobe fall for the hold time.
// - Write enable stays high after a read until strobes rise.
// - 1024 refreshes issued every 16 ms.
// - Column-first refresh: column strobe low before and after the row strobe.
// - Write enable held high around the row strobe fall in refresh.
// - Page mode keeps the row open, each page cycle at least 40 ns.
// - Row strobe held low after the last column precharge of a page.
// - Write data driven only after the module's read outputs are off.
// - Output enable hold and long cycle rule only matter for read-modify-write.
// - Page read-modify-write timing not used; no late write enable issued.
// - Read column strobe lengthened past 15 ns to keep the data window.
// - One position read at a time by its own presence enable.
// - Power-up pause of 200 us then 8 column-first refreshes.
module fpm_ctrl #(
    parameter int PWRUP_CYCLES = fpm_ctrl_pkg::C_PWRUP,
    parameter int REF_CYCLES = fpm_ctrl_pkg::C_REF_INT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input fpm_ctrl_pkg::mem_req_s req,
    output logic rd_valid,
    output logic [fpm_ctrl_pkg::DATA_BITS-1:0] rd_data,
    output logic [fpm_ctrl_pkg::PAR_BITS-1:0] rd_par,
    input wire logic pres_req,
    output logic pres_valid,
    output logic [fpm_ctrl_pkg::PRES_BITS-1:0] pres_value,
    output logic mismatch,
    output logic init_done,
    output fpm_ctrl_pkg::mem_ctl_s mem_ctl,
    output logic presence_enable_n,
    input wire logic [fpm_ctrl_pkg::PRES_BITS-1:0] presence_bits,
    input wire logic [fpm_ctrl_pkg::TYPE_BITS-1:0] card_type_bits,
    input wire logic [fpm_ctrl_pkg::DATA_BITS-1:0] data_lines_in,
    output logic [fpm_ctrl_pkg::DATA_BITS-1:0] data_lines_out,
    output logic data_lines_oe_n,
    input wire logic [fpm_ctrl_pkg::PAR_BITS-1:0] parity_lines_in,
    output logic [fpm_ctrl_pkg::PAR_BITS-1:0] parity_lines_out
);
    import fpm_ctrl_pkg::*;

    state_e state;
    logic [17:0] wait_cnt;
    logic [7:0] timer;
    logic [3:0] init_left;
    logic ref_pending;
    logic ref_ack;
    logic cur_write;
    logic cur_page;
    logic [ROW_BITS-1:0] open_row;
    logic [COL_BITS-1:0] cur_col;
    logic [7:0] since_ras;
    logic go;

    refresh_timer #(
        .INTERVAL(REF_CYCLES)
    ) u_refresh_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .ack(ref_ack),
        .pending(ref_pending)
    );

    // Accesses stall while a refresh is owed
    // Page follow-on only into the open row, once the column precharge is done
    assign req_ready = (state == ST_IDLE || (state == ST_CPRE && timer == TIMER_ZERO
            && req.row == open_row)) && !ref_pending && !pres_req;
    assign go = req_valid && req_ready;
    assign ref_ack = (state == ST_CBR_RAS) && (timer == TIMER_ZERO);
    assign mismatch = ~&card_type_bits;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wait_cnt <= 18'h00000;
        end else if (state == ST_INIT && wait_cnt != 18'(PWRUP_CYCLES)) begin
            wait_cnt <= wait_cnt + 18'h00001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst || state == ST_IDLE || state == ST_CPRE) begin
            since_ras <= 8'h00;
        end else if (since_ras != 8'hff) begin
            since_ras <= since_ras + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_INIT;
            timer <= TIMER_ZERO;
            init_left <= 4'(INIT_REFRESHES);
            init_done <= 1'b0;
            mem_ctl <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0};
            presence_enable_n <= 1'b1;
            data_lines_oe_n <= 1'b1;
            data_lines_out <= '0;
            parity_lines_out <= '0;
            rd_valid <= 1'b0;
            rd_data <= '0;
            rd_par <= '0;
            pres_valid <= 1'b0;
            pres_value <= '0;
            cur_write <= 1'b0;
            cur_page <= 1'b0;
            open_row <= '0;
            cur_col <= '0;
        end else begin
            rd_valid <= 1'b0;
            pres_valid <= 1'b0;
            if (timer != TIMER_ZERO) begin
                timer <= timer - 8'h01;
            end
            case (state)
                ST_INIT: begin
                    if (wait_cnt == 18'(PWRUP_CYCLES)) begin
                        state <= ST_CBR_SET;
                        mem_ctl.cas_n <= 1'b0;
                        mem_ctl.we_n <= 1'b1;
                        timer <= 8'(C_CSR);
                    end
                end
                ST_IDLE: begin
                    if (ref_pending) begin
                        state <= ST_CBR_SET;
                        mem_ctl.cas_n <= 1'b0;
                        mem_ctl.we_n <= 1'b1;
                        timer <= 8'(C_CSR);
                    end else if (pres_req) begin
                        state <= ST_PRES;
                        presence_enable_n <= 1'b0;
                        timer <= 8'(C_PD);
                    end else if (go) begin
                        state <= ST_ROW;
                        cur_write <= req.write;
                        cur_page <= req.page;
                        open_row <= req.row;
                        cur_col <= req.col;
                        mem_ctl.addr <= req.row;
                        data_lines_out <= req.data;
                        parity_lines_out <= req.par;
                        timer <= 8'h01;
                    end
                end
                ST_ROW: begin
                    if (timer == TIMER_ZERO) begin
                        mem_ctl.ras_n <= 1'b0;
                        state <= ST_COL;
                        timer <= 8'(C_RCD);
                    end
                end
                ST_COL: begin
                    if (timer == TIMER_ZERO) begin
                        // Column latched at take, so the requester may move on
                        mem_ctl.addr <= cur_col;
                        if (cur_write) begin
                            // Read outputs are off: column strobe and output enable still high so far
                            mem_ctl.we_n <= 1'b0;
                            data_lines_oe_n <= 1'b0;
                        end else begin
                            mem_ctl.oe_n <= 1'b0;
                        end
                        state <= ST_HOLD;
                        timer <= 8'h01;
                    end
                end
                ST_HOLD: begin
                    if (timer == TIMER_ZERO && mem_ctl.cas_n) begin
                        mem_ctl.cas_n <= 1'b0;
                        // Read strobe stretched for the data window
                        timer <= cur_write ? 8'(C_DH) : 8'(C_CAS_RD);
                    end else if (timer == TIMER_ZERO && (cur_write
                            || since_ras >= 8'(C_RAC))) begin
                        if (!cur_write) begin
                            rd_data <= data_lines_in;
                            rd_par <= parity_lines_in;
                            rd_valid <= 1'b1;
                        end
                        mem_ctl.cas_n <= 1'b1;
                        mem_ctl.oe_n <= 1'b1;
                        mem_ctl.we_n <= 1'b1;
                        data_lines_oe_n <= 1'b1;
                        state <= cur_page ? ST_CPRE : ST_PRE;
                        timer <= cur_page ? 8'(C_CP) : 8'(C_CPRH);
                    end
                end
                ST_CPRE: begin
                    // Next page access reuses the open row
                    if (go && req.row == open_row && timer == TIMER_ZERO) begin
                        cur_write <= req.write;
                        cur_page <= req.page;
                        cur_col <= req.col;
                        data_lines_out <= req.data;
                        parity_lines_out <= req.par;
                        state <= ST_COL;
                    end else if (timer == TIMER_ZERO) begin
                        state <= ST_PRE;
                        timer <= 8'(C_CPRH - C_CP);
                    end
                end
                ST_PRE: begin
                    if (timer == TIMER_ZERO && since_ras >= 8'(C_RAS)) begin
                        mem_ctl.ras_n <= 1'b1;
                        state <= ST_IDLE;
                        timer <= 8'(C_RP);
                    end
                end
                ST_CBR_SET: begin
                    if (timer == TIMER_ZERO) begin
                        mem_ctl.ras_n <= 1'b0;
                        state <= ST_CBR_RAS;
                        timer <= 8'(C_RAS);
                    end
                end
                ST_CBR_RAS: begin
                    if (timer == TIMER_ZERO) begin
                        mem_ctl.ras_n <= 1'b1;
                        mem_ctl.cas_n <= 1'b1;
                        timer <= 8'(C_RP);
                        if (!init_done && init_left != 4'h1) begin
                            init_left <= init_left - 4'h1;
                            state <= ST_INIT;
                        end else begin
                            init_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_PRES: begin
                    if (timer == TIMER_ZERO && !presence_enable_n) begin
                        pres_value <= presence_bits;
                        pres_valid <= 1'b1;
                        presence_enable_n <= 1'b1;
                        timer <= 8'(C_PDOFF);
                    end else if (timer == TIMER_ZERO) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> design/fpm_ctrl_pkg.sv
/*
 Package for the fast-page-mode memory module controller.
 Assumes a 25 MHz system clock; all pin timings become cycle counts here.
*/
package fpm_ctrl_pkg;
    localparam int CLK_NS = 40;
    localparam int ROW_BITS = 10;
    localparam int COL_BITS = 10;
    localparam int DATA_BITS = 64;
    localparam int PAR_BITS = 8;
    localparam int PRES_BITS = 8;
    localparam int TYPE_BITS = 2;
    // Least times in ns, rounded up to whole cycles (at least one)
    localparam int T_RP_NS = 40;
    localparam int T_RAS_NS = 60;
    localparam int T_RCD_NS = 18;
    localparam int T_CAS_NS = 15;
    localparam int T_OH_NS = 2;
    localparam int T_RAC_NS = 60;
    localparam int T_CSR_NS = 15;
    localparam int T_CHR_NS = 18;
    localparam int T_DH_NS = 20;
    localparam int T_PD_NS = 10;
    localparam int T_PDOFF_NS = 10;
    localparam int T_CPRH_NS = 40;
    localparam int T_CP_NS = 10;
    localparam int T_WP_NS = 15;
    function automatic int up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int C_RP = up(T_RP_NS);
    localparam int C_RAS = up(T_RAS_NS);
    localparam int C_RCD = up(T_RCD_NS);
    localparam int C_CAS_RD = up(T_CAS_NS + T_OH_NS);
    localparam int C_RAC = up(T_RAC_NS);
    localparam int C_CSR = up(T_CSR_NS);
    localparam int C_CHR = up(T_CHR_NS);
    localparam int C_DH = up(T_DH_NS);
    localparam int C_PD = up(T_PD_NS);
    localparam int C_PDOFF = up(T_PDOFF_NS);
    localparam int C_CPRH = up(T_CPRH_NS);
    localparam int C_CP = up(T_CP_NS);
    localparam int C_WP = up(T_WP_NS);
    // Refresh: 1024 rows per 16 ms
    localparam int REF_ROWS = 1024;
    localparam int T_REF_MS = 16;
    localparam int C_REF_INT = (T_REF_MS * 1000000 / REF_ROWS) / CLK_NS;
    localparam int T_PWRUP_US = 200;
    localparam int C_PWRUP = T_PWRUP_US * 1000 / CLK_NS;
    localparam int INIT_REFRESHES = 8;
    localparam logic [7:0] TIMER_ZERO = 8'h00;

    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic oe_n;
        logic [ROW_BITS-1:0] addr;
    } mem_ctl_s;

    typedef struct packed {
        logic write;
        logic page;
        logic [ROW_BITS-1:0] row;
        logic [COL_BITS-1:0] col;
        logic [DATA_BITS-1:0] data;
        logic [PAR_BITS-1:0] par;
    } mem_req_s;

    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_IDLE = 4'h1,
        ST_ROW = 4'h3,
        ST_COL = 4'h2,
        ST_HOLD = 4'h6,
        ST_PRE = 4'h7,
        ST_CPRE = 4'h5,
        ST_CBR_SET = 4'h4,
        ST_CBR_RAS = 4'hc,
        ST_PRES = 4'hd
    } state_e;
endpackage

// >>> design/refresh_timer.sv
/*
 Refresh interval timer: raises a pending flag every interval, cleared on service.
 Assumes the controller acknowledges by a one-cycle pulse.
*/
`timescale 1ns/1ps
module refresh_timer #(
    parameter int INTERVAL = fpm_ctrl_pkg::C_REF_INT
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ack,
    output logic pending
);
    import fpm_ctrl_pkg::*;
    logic [15:0] count;

    always_ff @(posedge clk_sys) begin
        if (rst || count == 16'(INTERVAL - 1)) begin
            count <= 16'h0000;
        end else begin
            count <= count + 16'h0001;
        end
    end

    // Expiry wins over a same-cycle acknowledge
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pending <= 1'b0;
        end else if (count == 16'(INTERVAL - 1)) begin
            pending <= 1'b1;
        end else if (ack) begin
            pending <= 1'b0;
        end
    end
endmodule

// >>> tb/dimm_model.sv
/*
 Behavioural model of the memory module on the far side of the controller.
 Assumes pull-ups on presence bits; data lines have none and show junk when off.
*/
`timescale 1ns/1ps
module dimm_model #(
    parameter logic [7:0] PRES_CODE = 8'h5a
) (
    input fpm_ctrl_pkg::mem_ctl_s mem_ctl,
    input wire logic presence_enable_n,
    input wire logic [fpm_ctrl_pkg::DATA_BITS-1:0] data_lines_out,
    input wire logic data_lines_oe_n,
    input wire logic [fpm_ctrl_pkg::PAR_BITS-1:0] parity_lines_out,
    output logic [fpm_ctrl_pkg::DATA_BITS-1:0] data_lines_in,
    output logic [fpm_ctrl_pkg::PAR_BITS-1:0] parity_lines_in,
    output logic [fpm_ctrl_pkg::PRES_BITS-1:0] presence_bits
);
    import fpm_ctrl_pkg::*;
    logic [PAR_BITS+DATA_BITS-1:0] cells [logic [19:0]];
    logic [PAR_BITS+DATA_BITS-1:0] q = '0;
    logic [ROW_BITS-1:0] row;
    logic rd;
    logic drv = 1'b0;
    always @(negedge mem_ctl.ras_n) row = mem_ctl.addr;
    // Refresh falls with the row strobe high, so it stores nothing
    always @(negedge mem_ctl.cas_n) begin
        if (!mem_ctl.ras_n && !mem_ctl.we_n) begin
            cells[{row, mem_ctl.addr}] = data_lines_oe_n ? 'x : {parity_lines_out, data_lines_out};
        end else if (!mem_ctl.ras_n) begin
            q = cells.exists({row, mem_ctl.addr}) ? cells[{row, mem_ctl.addr}] : '0;
        end
    end
    // Write enable falling inside the column strobe: late write or read-modify-write
    always @(negedge mem_ctl.we_n) begin
        if (!mem_ctl.ras_n && !mem_ctl.cas_n) begin
            cells[{row, mem_ctl.addr}] = {parity_lines_out, data_lines_out};
        end
    end
    assign rd = !mem_ctl.ras_n && !mem_ctl.cas_n && mem_ctl.we_n && !mem_ctl.oe_n;
    // Only column and enable access modelled; row access is always shorter here
    always @(rd) drv <= #(rd ? 20 : 15) rd;
    assign {parity_lines_in, data_lines_in} = drv ? q : ~q;
    assign #10 presence_bits = presence_enable_n ? 8'hff : PRES_CODE;
endmodule

// >>> tb/fpm_ctrl_properties.sv
/*
 Pin-timing checker for the memory module controller.
 Assumes it is bound into fpm_ctrl and handed the same count parameters.
*/
`timescale 1ns/1ps
module fpm_ctrl_properties #(
    parameter int PWRUP_CYCLES = 20,
    parameter int REF_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rd_valid,
    input wire logic pres_valid,
    input wire logic mismatch,
    input wire logic init_done,
    input fpm_ctrl_pkg::mem_ctl_s mem_ctl,
    input wire logic presence_enable_n,
    input wire logic [fpm_ctrl_pkg::TYPE_BITS-1:0] card_type_bits,
    input wire logic [fpm_ctrl_pkg::DATA_BITS-1:0] data_lines_out,
    input wire logic data_lines_oe_n
);
    import fpm_ctrl_pkg::*;
    logic ras, cas, we, oe;
    int gap, n_ref, cyc;
    assign ras = mem_ctl.ras_n;
    assign cas = mem_ctl.cas_n;
    assign we = mem_ctl.we_n;
    assign oe = mem_ctl.oe_n;
    // Gap since the last column-first refresh, and refreshes since reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            gap <= 0;
            n_ref <= 0;
            cyc <= 0;
        end else begin
            cyc <= cyc + 1;
            gap <= ($fell(ras) && !cas) ? 0 : gap + 1;
            n_ref <= n_ref + int'($fell(ras) && !cas);
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    cbr_setup_a: assert property (
        $fell(ras) && !cas |-> $past(!cas) && $past(we) && we) else $error("refresh setup");
    cbr_hold_a: assert property (
        $fell(ras) && !cas |=> !cas) else $error("refresh hold");
    early_write_a: assert property (
        $fell(cas) && !ras && !we |-> $past(!we)) else $error("write enable late");
    we_window_a: assert property (
        $fell(we) |-> cas) else $error("write enable between windows");
    data_hold_a: assert property (
        $fell(cas) && !we && !ras |=> !data_lines_oe_n && $stable(data_lines_out))
        else $error("write data hold");
    read_float_a: assert property (
        !cas && we && !ras |-> data_lines_oe_n) else $error("data driven in read");
    read_sample_a: assert property (
        rd_valid |-> $past(!cas) && $past(!oe) && $past(!ras, 2) && $past(we))
        else $error("read sampled early");
    read_we_a: assert property (
        $rose(cas) && !ras && $past(we) |-> we) else $error("write enable after read");
    refresh_gap_a: assert property (
        init_done |-> gap < REF_CYCLES + 32) else $error("refresh overdue");
    init_seq_a: assert property (
        $rose(init_done) |-> n_ref == INIT_REFRESHES && cyc >= PWRUP_CYCLES)
        else $error("init sequence");
    pres_answer_a: assert property (
        $fell(presence_enable_n) |-> ##[1:4] pres_valid) else $error("presence answer");
    type_flag_a: assert property (
        mismatch == (card_type_bits != 2'h3)) else $error("card type flag");
    page_hold_a: assert property (
        $rose(cas) && !ras |=> !ras) else $error("row closed early");
    cover property ($fell(cas) && !ras && $past(!ras, 6));
    cover property (rd_valid);
    cover property (pres_valid);
    cover property ($fell(ras) && !cas);
    cover property ($fell(cas) && !we);
endmodule
bind fpm_ctrl fpm_ctrl_properties #(
    .PWRUP_CYCLES(PWRUP_CYCLES), .REF_CYCLES(REF_CYCLES)
) fpm_ctrl_properties_inst (
    .clk_sys(clk_sys), .rst(rst), .rd_valid(rd_valid), .pres_valid(pres_valid),
    .mismatch(mismatch), .init_done(init_done), .mem_ctl(mem_ctl),
    .presence_enable_n(presence_enable_n), .card_type_bits(card_type_bits),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n)
);

// >>> tb/tb_fpm_ctrl.sv
/*
 Self-checking bench for the memory module controller.
 Assumes the module model and the bound pin checker sit beside it.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected at %0t ns: got %h expected %h", $time, g, e); end end
module tb_fpm_ctrl;
    import fpm_ctrl_pkg::*;
    localparam logic [7:0] PRES_CODE = 8'h5a;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic pres_req = 1'b0;
    mem_req_s req = '0;
    logic [TYPE_BITS-1:0] card_type_bits = 2'h3;
    logic req_ready, rd_valid, pres_valid, mismatch, init_done, presence_enable_n;
    logic data_lines_oe_n;
    logic [DATA_BITS-1:0] rd_data, data_lines_in, data_lines_out;
    logic [PAR_BITS-1:0] rd_par, parity_lines_in, parity_lines_out;
    logic [PRES_BITS-1:0] pres_value, presence_bits;
    mem_ctl_s mem_ctl;
    logic [71:0] got, want;
    logic [71:0] expq [$];
    logic [71:0] shadow [logic [19:0]];
    logic [19:0] addrs [$];
    int n_mismatch = 0;
    int checks = 0;
    always #20 clk_sys = ~clk_sys;
    // Short counts keep the run brief
    fpm_ctrl #(.PWRUP_CYCLES(20), .REF_CYCLES(200)) fpm_ctrl_inst (
        .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rd_valid(rd_valid), .rd_data(rd_data), .rd_par(rd_par),
        .pres_req(pres_req), .pres_valid(pres_valid), .pres_value(pres_value),
        .mismatch(mismatch), .init_done(init_done), .mem_ctl(mem_ctl),
        .presence_enable_n(presence_enable_n), .presence_bits(presence_bits),
        .card_type_bits(card_type_bits), .data_lines_in(data_lines_in),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
        .parity_lines_in(parity_lines_in), .parity_lines_out(parity_lines_out));
    dimm_model #(.PRES_CODE(PRES_CODE)) dimm_model_inst (
        .mem_ctl(mem_ctl), .presence_enable_n(presence_enable_n),
        .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
        .parity_lines_out(parity_lines_out), .data_lines_in(data_lines_in),
        .parity_lines_in(parity_lines_in), .presence_bits(presence_bits));
    task automatic print_verdict();
        if (n_mismatch == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Request held until taken, so page follow-ons can land in the open row
    task automatic access(input logic w, input logic [19:0] a);
        @(negedge clk_sys);
        req = '{w, 1'($urandom), a[19:10], a[9:0], {$urandom, $urandom}, 8'($urandom)};
        if (w) shadow[a] = {req.par, req.data};
        else expq.push_back(shadow[a]);
        req_valid = 1'b1;
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 1'b0;
    endtask
    task automatic presence();
        while (expq.size() != 0) @(negedge clk_sys);
        expq.push_back({64'h0, PRES_CODE});
        pres_req = 1'b1;
        do @(negedge clk_sys); while (presence_enable_n !== 1'b0);
        pres_req = 1'b0;
        do @(negedge clk_sys); while (pres_valid !== 1'b1);
    endtask
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1 || pres_valid === 1'b1) begin
            got = rd_valid ? {rd_par, rd_data} : {64'h0, pres_value};
            want = expq.size() != 0 ? expq.pop_front() : {72{1'bx}};
            `CHK(got, want)
        end
    end
    initial begin
        void'($urandom(32'h4025ec66));
        repeat (5) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        `CHK(req_ready, 1'b0)
        while (init_done !== 1'b1) @(negedge clk_sys);
        addrs = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00};
        repeat (12) addrs.push_back(20'($urandom));
        foreach (addrs[i]) access(1'b1, addrs[i]);
        // Long mixed run so refresh lands between accesses
        repeat (120) access(1'($urandom), addrs[$urandom % addrs.size()]);
        for (int t = 0; t < 4; t++) begin
            card_type_bits = t[1:0];
            @(negedge clk_sys);
            `CHK(mismatch, t != 3)
        end
        repeat (2) presence();
        while (expq.size() != 0) @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
        print_verdict();
    end
    initial begin
        #(40 * 20000);
        n_mismatch++;
        print_verdict();
    end
endmodule
